// ### alm_core.sv
// Alarm latch, follow-up action and LED acknowledge stage with a Wishbone register file.
// Contract
// RL1 - Unacknowledged active alarm flashes LED fast; dropped-out unacknowledged flashes slow.
// RL2 - Display acknowledge stops LED flashing only, action unchanged unless display resets.
// RL3 - Display enabled as reset source makes its acknowledge also reset the action.
// RL4 - Without acknowledge-required configuration, no pending acknowledge state is held.
// RL5 - Without alarm reset, action follows the alarm and drops with the condition.
// RL6 - With alarm reset, alarm latches until a reset after the condition is gone.
// RL7 - Alarm reset comes from display, digital input, logic state or bus command.
// RL8 - Every alarm reset also acknowledges the LED indication.
// RL9 - Combined condition is the configured gate over all used logic inputs.
// RL10 - Delayed condition follows combined, rises after switch-in, falls after dropout.
// RL11 - Action equals alarm output, inverted when configured as inverted.
// RL12 - After a gain change measurement inputs stay frozen at least one cycle.
// RL13 - Evaluation runs once per line cycle, gaps never above 25 ms.
// RL14 - LED is off with no alarm and no pending acknowledge.
`timescale 1ns/1ps
`include "alm_params.svh"
module alm_core #(
    parameter int EVAL_MAX_CYC = `ALM_EVAL_MAX_MS * (`ALM_CLK_HZ / 1000),
    parameter int DLY_W        = 16
) (
    input  wire logic        CLK,       // System clock, 125 MHz.
    input  wire logic        RST_N,     // Synchronous reset, active low.
    input  wire logic [7:0]  ADR_I,     // Wishbone byte address.
    input  wire logic [31:0] DAT_I,     // Wishbone write data.
    output logic      [31:0] DAT_O,     // Wishbone read data.
    input  wire logic [3:0]  SEL_I,     // Wishbone byte selects.
    input  wire logic        WE_I,      // Wishbone write enable.
    input  wire logic        CYC_I,     // Wishbone cycle.
    input  wire logic        STB_I,     // Wishbone strobe.
    output logic             ACK_O,     // Wishbone acknowledge.
    input  wire logic        LINE_TICK, // One pulse per power-frequency cycle.
    input  wire logic        GAIN_CHG,  // Pulse on an amplification level change.
    input  wire logic [3:0]  LIM_IN,    // Logic input states.
    input  wire logic        DISP_ACK,  // Acknowledge pulse from the display.
    input  wire logic        DIN_RST,   // Alarm reset from a digital input.
    input  wire logic        LOGIC_RST, // Alarm reset from another logic state.
    output logic             RELAY,     // Follow-up action state.
    output logic             ALARM,     // Alarm output.
    output logic             LED,       // Alarm LED.
    output logic             IRQ        // Interrupt, level, active high.
);
    logic [31:0] ctrl;
    logic [31:0] dly;
    logic [3:0]  irq_st;
    logic [3:0]  irq_mask;
    logic        ack;
    logic [31:0] rdata;
    logic        bus_rst;
    logic [31:0] next_ctrl;
    logic [31:0] next_dly;
    logic [3:0]  next_irq_st;
    logic [3:0]  next_irq_mask;
    logic        next_ack;
    logic [31:0] next_rdata;
    logic        next_bus_rst;
    logic [31:0] gap_cnt;
    logic [31:0] next_gap_cnt;
    logic        tick;
    logic        forced;
    logic [3:0]  samp;
    logic [3:0]  next_samp;
    logic        frozen;
    logic        next_frozen;
    logic [1:0]  frz_cnt;
    logic [1:0]  next_frz_cnt;
    logic        comb_q;
    logic        next_comb_q;
    logic        delayed;
    alm_pkg::alm_state_t state;
    alm_pkg::alm_state_t next_state;
    logic        led_pend;
    logic        next_led_pend;
    logic [7:0]  flash_cnt;
    logic [7:0]  next_flash_cnt;
    logic        next_relay;
    logic        next_led;
    logic        active;
    logic        rise;
    logic        rst_any;
    logic        wr;
    logic [3:0]  ev;
    alm_pkg::alm_cfg_t  cfg;
    alm_pkg::alm_stat_t stat;

    // Unused inputs take the level that leaves the gate result unchanged.
    function automatic logic combine(input logic [3:0] x, input logic [3:0] used, input alm_pkg::alm_gate_t g);
        logic [3:0] ones;
        logic [3:0] zeros;
        ones  = x | ~used;
        zeros = x & used;
        case (g)
            alm_pkg::GATE_AND:  combine = &ones;
            alm_pkg::GATE_NAND: combine = ~&ones;
            alm_pkg::GATE_OR:   combine = |zeros;
            alm_pkg::GATE_NOR:  combine = ~|zeros;
            alm_pkg::GATE_XOR:  combine = ^zeros;
            alm_pkg::GATE_XNOR: combine = ~^zeros;
            default:            combine = 1'b0;
        endcase
    endfunction : combine

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] sel);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                merge[i*8 +: 8] = val[i*8 +: 8];
            end
        end
    endfunction : merge

    assign cfg.gate     = alm_pkg::alm_gate_t'(ctrl[`ALM_F_GATE]);
    assign cfg.use_mask = ctrl[`ALM_F_USE];
    assign cfg.latch    = ctrl[`ALM_B_LATCH];
    assign cfg.invert   = ctrl[`ALM_B_INVERT];
    assign cfg.ack_req  = ctrl[`ALM_B_ACKREQ];
    assign cfg.rst_src  = alm_pkg::alm_src_t'(ctrl[`ALM_F_RSTSRC]);
    assign active       = (state != alm_pkg::ALM_IDLE);
    assign ALARM        = active;
    assign ACK_O        = ack;
    assign DAT_O        = rdata;
    assign IRQ          = |(irq_st & irq_mask);

    // Any enabled source resets the alarm.
    assign rst_any = (DISP_ACK && cfg.rst_src.disp) || (DIN_RST && cfg.rst_src.din) // RL3 RL7
                  || (LOGIC_RST && cfg.rst_src.logic_state) || (bus_rst && cfg.rst_src.bus); // RL7

    // Line-cycle tick, or a forced one if the line goes quiet for the longest gap.
    assign forced = !LINE_TICK && (gap_cnt >= 32'(EVAL_MAX_CYC - 1)); // RL13
    assign tick   = LINE_TICK || forced; // RL13

    always_comb begin
        next_gap_cnt = tick ? 32'h0000_0000 : gap_cnt + 32'h0000_0001;
        next_frozen  = frozen;
        next_frz_cnt = frz_cnt;
        if (GAIN_CHG) begin
            next_frozen  = 1'b1; // RL12
            next_frz_cnt = 2'h0;
        end else if (frozen && tick) begin
            next_frz_cnt = frz_cnt + 2'h1;
            if (frz_cnt == 2'(`ALM_FREEZE_TICKS - 1)) begin
                next_frozen = 1'b0; // RL12
            end
        end
        next_samp   = (tick && !frozen && !GAIN_CHG) ? LIM_IN : samp; // RL12
        next_comb_q = tick ? combine(samp, cfg.use_mask, cfg.gate) : comb_q; // RL9
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            gap_cnt <= 32'h0000_0000;
            frozen  <= 1'b0;
            frz_cnt <= 2'h0;
            samp    <= 4'h0;
            comb_q  <= 1'b0;
        end else begin
            gap_cnt <= next_gap_cnt;
            frozen  <= next_frozen;
            frz_cnt <= next_frz_cnt;
            samp    <= next_samp;
            comb_q  <= next_comb_q;
        end
    end

    alm_delay #(
        .W (DLY_W)
    ) u_delay (
        .clk     (CLK),
        .rst_n   (RST_N),
        .tick    (tick),
        .din     (comb_q),
        .on_dly  (dly[DLY_W-1:0]),
        .off_dly (dly[DLY_W+15:16]),
        .dout    (delayed)
    );

    assign rise = (state == alm_pkg::ALM_IDLE) && delayed;

    // Alarm state: idle, active, or held after dropout until a reset.
    always_comb begin
        case (state)
            alm_pkg::ALM_IDLE: begin
                next_state = delayed ? alm_pkg::ALM_ACTIVE : alm_pkg::ALM_IDLE;
            end
            alm_pkg::ALM_ACTIVE: begin
                if (delayed) begin
                    next_state = alm_pkg::ALM_ACTIVE;
                end else if (cfg.latch && !rst_any) begin
                    next_state = alm_pkg::ALM_HELD; // RL6
                end else begin
                    next_state = alm_pkg::ALM_IDLE; // RL5
                end
            end
            alm_pkg::ALM_HELD: begin
                if (delayed) begin
                    next_state = alm_pkg::ALM_ACTIVE;
                end else if (rst_any || !cfg.latch) begin
                    next_state = alm_pkg::ALM_IDLE; // RL6
                end else begin
                    next_state = alm_pkg::ALM_HELD;
                end
            end
            default: begin
                next_state = alm_pkg::ALM_IDLE;
            end
        endcase
        // A new occurrence wins over an acknowledge in the same cycle.
        if (!cfg.ack_req) begin
            next_led_pend = 1'b0; // RL4
        end else if (rise) begin
            next_led_pend = 1'b1;
        end else if (DISP_ACK || rst_any) begin
            next_led_pend = 1'b0; // RL2 RL8
        end else begin
            next_led_pend = led_pend;
        end
        next_flash_cnt = tick ? flash_cnt + 8'h01 : flash_cnt;
        next_relay     = (next_state != alm_pkg::ALM_IDLE) ^ cfg.invert; // RL11
        // A latched alarm whose condition has dropped out flashes slowly as well.
        if (led_pend) begin
            next_led = (state == alm_pkg::ALM_ACTIVE) ? flash_cnt[`ALM_FAST_BIT] : flash_cnt[`ALM_SLOW_BIT]; // RL1
        end else begin
            next_led = active; // RL14
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state     <= alm_pkg::ALM_IDLE;
            led_pend  <= 1'b0;
            flash_cnt <= 8'h00;
            RELAY     <= 1'b0;
            LED       <= 1'b0;
        end else begin
            state     <= next_state;
            led_pend  <= next_led_pend;
            flash_cnt <= next_flash_cnt;
            RELAY     <= next_relay;
            LED       <= next_led;
        end
    end

    assign stat = '{frozen: frozen, led_pend: led_pend, action: RELAY,
                    active: active, delayed: delayed, combined: comb_q};
    assign wr = CYC_I && STB_I && WE_I && !ack;
    assign ev = {GAIN_CHG, forced, rst_any, rise};

    // Single-cycle answer; unmapped reads return zero and writes are dropped.
    always_comb begin
        next_ack      = CYC_I && STB_I && !ack;
        next_ctrl     = ctrl;
        next_dly      = dly;
        next_irq_mask = irq_mask;
        next_bus_rst  = 1'b0;
        next_irq_st   = irq_st;
        next_rdata    = 32'h0000_0000;
        if (wr) begin
            case (ADR_I)
                `ALM_ADR_CTRL:  next_ctrl     = merge(ctrl, DAT_I, SEL_I);
                `ALM_ADR_DELAY: next_dly      = merge(dly, DAT_I, SEL_I);
                `ALM_ADR_CMD:   next_bus_rst  = SEL_I[0] && DAT_I[`ALM_B_CMD_RST]; // RL7
                `ALM_ADR_IRQ:   next_irq_st   = SEL_I[0] ? irq_st & ~DAT_I[3:0] : irq_st;
                `ALM_ADR_MASK:  next_irq_mask = SEL_I[0] ? DAT_I[3:0] : irq_mask;
                default:        next_ctrl     = ctrl;
            endcase
        end else if (CYC_I && STB_I && !ack) begin
            case (ADR_I)
                `ALM_ADR_CTRL:   next_rdata = ctrl;
                `ALM_ADR_DELAY:  next_rdata = dly;
                `ALM_ADR_STATUS: next_rdata = {26'h0, stat};
                `ALM_ADR_IRQ:    next_rdata = {28'h0, irq_st};
                `ALM_ADR_MASK:   next_rdata = {28'h0, irq_mask};
                default:         next_rdata = 32'h0000_0000;
            endcase
        end
        next_irq_st = next_irq_st | ev;
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ack      <= 1'b0;
            ctrl     <= `ALM_CTRL_RST;
            dly      <= `ALM_DELAY_RST;
            irq_st   <= 4'h0;
            irq_mask <= 4'h0;
            rdata    <= 32'h0000_0000;
            bus_rst  <= 1'b0;
        end else begin
            ack      <= next_ack;
            ctrl     <= next_ctrl;
            dly      <= next_dly;
            irq_st   <= next_irq_st;
            irq_mask <= next_irq_mask;
            rdata    <= next_rdata;
            bus_rst  <= next_bus_rst;
        end
    end

    a_fast_flash: assert property (@(posedge CLK) disable iff (!RST_N) // RL1
        (led_pend && state == alm_pkg::ALM_ACTIVE) |=> (LED == $past(flash_cnt[`ALM_FAST_BIT])))
        else $error("active unacknowledged alarm not on fast flash");
    a_slow_flash: assert property (@(posedge CLK) disable iff (!RST_N) // RL1
        (led_pend && state != alm_pkg::ALM_ACTIVE) |=> (LED == $past(flash_cnt[`ALM_SLOW_BIT])))
        else $error("dropped unacknowledged alarm not on slow flash");
    a_ack_led_only: assert property (@(posedge CLK) disable iff (!RST_N) // RL2
        (DISP_ACK && !cfg.rst_src.disp && !rise && state == alm_pkg::ALM_HELD && !delayed
         && cfg.latch && !DIN_RST && !LOGIC_RST && !bus_rst) |=> (!led_pend && state == alm_pkg::ALM_HELD))
        else $error("display acknowledge touched the action");
    a_disp_reset: assert property (@(posedge CLK) disable iff (!RST_N) // RL3
        (DISP_ACK && cfg.rst_src.disp && state == alm_pkg::ALM_HELD && !delayed)
        |=> state == alm_pkg::ALM_IDLE)
        else $error("display reset source did not reset the alarm");
    a_no_pend: assert property (@(posedge CLK) disable iff (!RST_N) // RL4
        !cfg.ack_req |=> !led_pend)
        else $error("pending acknowledge held while not required");
    a_auto_drop: assert property (@(posedge CLK) disable iff (!RST_N) // RL5
        (!cfg.latch && !delayed) |=> !ALARM ##1 ($past(delayed) || RELAY == $past(cfg.invert)))
        else $error("alarm not withdrawn without latching");
    a_latch_hold: assert property (@(posedge CLK) disable iff (!RST_N) // RL6
        (cfg.latch && active && !rst_any) |=> active)
        else $error("latched alarm lost without reset");
    a_reset_ack: assert property (@(posedge CLK) disable iff (!RST_N) // RL8
        (rst_any && !rise) |=> !led_pend)
        else $error("alarm reset did not acknowledge the LED");
    a_relay_inv: assert property (@(posedge CLK) disable iff (!RST_N) // RL11
        ##1 (RELAY == (active ^ $past(cfg.invert))))
        else $error("action does not match alarm and inversion");
    a_freeze_hold: assert property (@(posedge CLK) disable iff (!RST_N) // RL12
        GAIN_CHG |=> (frozen && $stable(samp)))
        else $error("inputs not frozen after gain change");
    a_eval_gap: assert property (@(posedge CLK) disable iff (!RST_N) // RL13
        gap_cnt < 32'(EVAL_MAX_CYC))
        else $error("evaluation gap exceeded the longest interval");
    a_led_off: assert property (@(posedge CLK) disable iff (!RST_N) // RL14
        (!led_pend && !active) |=> !LED)
        else $error("LED lit with no alarm pending");
endmodule : alm_core

// ### alm_params.svh
// Register offsets, field positions, reset values and timing counts of the alarm block.
`ifndef ALM_PARAMS_SVH
`define ALM_PARAMS_SVH
`define ALM_ADR_CTRL    8'h00
`define ALM_ADR_DELAY   8'h04
`define ALM_ADR_CMD     8'h08
`define ALM_ADR_STATUS  8'h0c
`define ALM_ADR_IRQ     8'h10
`define ALM_ADR_MASK    8'h14
`define ALM_F_GATE      2:0
`define ALM_F_USE       7:4
`define ALM_B_LATCH     8
`define ALM_B_INVERT    9
`define ALM_B_ACKREQ    10
`define ALM_F_RSTSRC    15:12
`define ALM_F_ON_DLY    15:0
`define ALM_F_OFF_DLY   31:16
`define ALM_B_CMD_RST   0
`define ALM_CTRL_RST    32'h0000_04f1
`define ALM_DELAY_RST   32'h0000_0000
`define ALM_IRQ_RISE    0
`define ALM_IRQ_RESET   1
`define ALM_IRQ_FORCED  2
`define ALM_IRQ_FREEZE  3
`define ALM_CLK_HZ      125000000
`define ALM_EVAL_MAX_MS 25
`define ALM_FREEZE_TICKS 2
`define ALM_FAST_BIT    3
`define ALM_SLOW_BIT    5
`endif

// ### alm_pkg.sv
// Types shared by the alarm block.
package alm_pkg;
    typedef enum logic [2:0] {
        ALM_IDLE   = 3'b001,
        ALM_ACTIVE = 3'b010,
        ALM_HELD   = 3'b100
    } alm_state_t;
    typedef enum logic [2:0] {
        GATE_AND  = 3'h0,
        GATE_OR   = 3'h1,
        GATE_XOR  = 3'h2,
        GATE_NAND = 3'h3,
        GATE_NOR  = 3'h4,
        GATE_XNOR = 3'h5
    } alm_gate_t;
    typedef struct packed {
        logic bus;
        logic logic_state;
        logic din;
        logic disp;
    } alm_src_t;
    typedef struct packed {
        alm_src_t   rst_src;
        logic       ack_req;
        logic       invert;
        logic       latch;
        logic [3:0] use_mask;
        alm_gate_t  gate;
    } alm_cfg_t;
    typedef struct packed {
        logic frozen;
        logic led_pend;
        logic action;
        logic active;
        logic delayed;
        logic combined;
    } alm_stat_t;
endpackage : alm_pkg

// ### alm_delay.sv
// Switch-in and dropout delay of the combined condition, counted in evaluation ticks.
`timescale 1ns/1ps
module alm_delay #(
    parameter int W = 16
) (
    input  wire logic         clk,     // System clock.
    input  wire logic         rst_n,   // Synchronous reset, active low.
    input  wire logic         tick,    // Evaluation tick.
    input  wire logic         din,     // Combined condition.
    input  wire logic [W-1:0] on_dly,  // Switch-in delay in ticks.
    input  wire logic [W-1:0] off_dly, // Dropout delay in ticks.
    output logic              dout     // Delayed condition.
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic         next_dout;

    // The count restarts whenever the input returns to the output level.
    always_comb begin
        next_cnt  = cnt;
        next_dout = dout;
        if (tick) begin
            if (din == dout) begin
                next_cnt = '0;
            end else if (cnt >= (din ? on_dly : off_dly)) begin // RL10
                next_dout = din;
                next_cnt  = '0;
            end else begin
                next_cnt = cnt + W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt  <= '0;
            dout <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            dout <= next_dout;
        end
    end

    a_zero_on_delay: assert property (@(posedge clk) disable iff (!rst_n) // RL10
        (tick && din && !dout && on_dly == '0) |=> dout)
        else $error("switch-in delay zero did not pass at once");
    a_hold_unt_tick: assert property (@(posedge clk) disable iff (!rst_n) // RL10
        !tick |=> $stable(dout))
        else $error("delayed condition moved without a tick");
endmodule : alm_delay

// ### alm_panel.sv
// Model of the operator panel side: line tick, display acknowledge and reset request pulses.
`timescale 1ns/1ps
module alm_panel #(
    parameter int TICK_CYC = 20
) (
    input  wire logic       clk,       // System clock.
    input  wire logic       rst_n,     // Synchronous reset, active low.
    input  wire logic       tick_en,   // Line voltage present.
    input  wire logic       press,     // One-cycle request from the bench.
    input  wire logic [1:0] kind,      // 0 display, 1 digital input, 2 logic state.
    output logic            disp_ack,  // Display acknowledge pulse.
    output logic            din_rst,   // Digital input reset pulse.
    output logic            logic_rst, // Logic state reset pulse.
    output logic            line_tick  // One pulse per line cycle.
);
    int cnt;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt       <= 0;
            line_tick <= 1'b0;
            disp_ack  <= 1'b0;
            din_rst   <= 1'b0;
            logic_rst <= 1'b0;
        end else begin
            cnt       <= (cnt == TICK_CYC - 1) ? 0 : cnt + 1;
            line_tick <= tick_en && (cnt == TICK_CYC - 1);
            disp_ack  <= press && (kind == 2'h0);
            din_rst   <= press && (kind == 2'h1);
            logic_rst <= press && (kind == 2'h2);
        end
    end
endmodule : alm_panel

// ### testbench.sv
// Self-checking bench of the alarm core with a panel model and a Wishbone master.
`timescale 1ns/1ps
`include "alm_params.svh"
module testbench;
    localparam int TCYC = 20;
    logic        clk, rst_n, we, cyc, stb, gain_chg, tick_en, press;
    logic [7:0]  adr;
    logic [31:0] dat_w, dat_r, rdata, seed;
    logic [3:0]  sel, lim, u, v;
    logic [1:0]  kind;
    logic        ack, tick, disp_ack, din_rst, logic_rst, relay, alarm, led, irq;
    int          failures, checks_done, n;

    alm_core #(.EVAL_MAX_CYC(200), .DLY_W(16)) u_alm_core (.CLK(clk), .RST_N(rst_n), .ADR_I(adr),
        .DAT_I(dat_w), .DAT_O(dat_r), .SEL_I(sel), .WE_I(we), .CYC_I(cyc), .STB_I(stb), .ACK_O(ack),
        .LINE_TICK(tick), .GAIN_CHG(gain_chg), .LIM_IN(lim), .DISP_ACK(disp_ack), .DIN_RST(din_rst),
        .LOGIC_RST(logic_rst), .RELAY(relay), .ALARM(alarm), .LED(led), .IRQ(irq));
    alm_panel #(.TICK_CYC(TCYC)) u_alm_panel (.clk(clk), .rst_n(rst_n), .tick_en(tick_en), .press(press),
        .kind(kind), .disp_ack(disp_ack), .din_rst(din_rst), .logic_rst(logic_rst), .line_tick(tick));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    function automatic logic gate_exp(input logic [2:0] g, input logic [3:0] um, input logic [3:0] iv);
        logic [3:0] a, o;
        a = iv | ~um;
        o = iv & um;
        case (g)
            3'h0: return &a;
            3'h1: return |o;
            3'h2: return ^o;
            3'h3: return ~&a;
            3'h4: return ~|o;
            3'h5: return ~^o;
            default: return 1'b0;
        endcase
    endfunction : gate_exp

    function automatic logic [31:0] ctrl(input logic [3:0] src, input logic ak, input logic inv,
                                         input logic lat, input logic [3:0] um, input logic [2:0] g);
        return {16'h0000, src, 1'b0, ak, inv, lat, um, 1'b0, g};
    endfunction : ctrl

    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        dat_w <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rdata = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb

    task automatic settle(input int t);
        repeat (t) @(posedge clk iff tick);
        repeat (6) @(posedge clk);
    endtask : settle

    task automatic push(input logic [1:0] k);
        @(posedge clk);
        press <= 1'b1;
        kind  <= k;
        @(posedge clk);
        press <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : push

    task automatic led_edges(output int e);
        logic p;
        e = 0;
        p = led;
        repeat (64 * TCYC) begin
            @(posedge clk);
            if (led !== p) begin
                e++;
            end
            p = led;
        end
    endtask : led_edges

    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        report_and_stop();
    end

    initial begin
        {rst_n, we, cyc, stb, gain_chg, tick_en, press, kind, lim} = '0;
        {adr, dat_w} = '0;
        sel  = 4'hf;
        seed = 32'h0000_0034;
        repeat (2) @(posedge clk);
        rst_n   <= 1'b1;
        tick_en <= 1'b1;
        wb(1'b0, `ALM_ADR_CTRL, 32'h0);
        check("ctrl reset", rdata, `ALM_CTRL_RST);
        wb(1'b0, 8'h3c, 32'h0);
        check("unmapped read", rdata, 32'h0);
        check("led idle", led, 1'b0);
        for (int i = 0; i < 16; i++) begin
            u = 4'(xs()) | 4'h1;
            v = 4'(xs());
            wb(1'b1, `ALM_ADR_CTRL, ctrl(4'h0, 1'b1, 1'b0, 1'b0, u, i[2:0]));
            lim <= v;
            settle(3);
            wb(1'b0, `ALM_ADR_STATUS, 32'h0);
            check("combined", rdata[0], gate_exp(i[2:0], u, v));
        end
        wb(1'b1, `ALM_ADR_CTRL, ctrl(4'h0, 1'b1, 1'b0, 1'b0, 4'h1, 3'h1));
        lim <= 4'h0;
        settle(4);
        push(2'h0);
        check("led off", led, 1'b0);
        lim <= 4'h1;
        settle(4);
        check("relay on", relay, 1'b1);
        led_edges(n);
        check("fast flash", n >= 6, 1'b1);
        lim <= 4'h0;
        settle(4);
        check("relay off", relay, 1'b0);
        led_edges(n);
        check("slow flash", n >= 1 && n <= 3, 1'b1);
        push(2'h0);
        check("led acked", led, 1'b0);
        wb(1'b1, `ALM_ADR_CTRL, ctrl(4'h0, 1'b1, 1'b1, 1'b0, 4'h1, 3'h1));
        repeat (4) @(posedge clk);
        check("inverted idle", relay, 1'b1);
        lim <= 4'h1;
        settle(4);
        check("inverted alarm", {alarm, relay}, 2'b10);
        lim <= 4'h0;
        settle(4);
        for (int k = 0; k < 4; k++) begin
            wb(1'b1, `ALM_ADR_CTRL, ctrl(4'h1 << k, 1'b1, 1'b0, 1'b1, 4'h1, 3'h1));
            lim <= 4'h1;
            settle(4);
            lim <= 4'h0;
            settle(4);
            check("latched", relay, 1'b1);
            if (k[0]) begin
                push(2'h0);
                check("ack keeps relay", {relay, led}, 2'b11);
            end else if (k == 2) begin
                led_edges(n);
                check("held slow flash", n >= 1 && n <= 3, 1'b1);
            end
            if (k == 3) begin
                wb(1'b1, `ALM_ADR_CMD, 32'h1);
                repeat (4) @(posedge clk);
            end else begin
                push(k[1:0]);
            end
            check("reset relay", relay, 1'b0);
            wb(1'b0, `ALM_ADR_STATUS, 32'h0);
            check("reset acks led", {led, rdata[4]}, 2'b00);
        end
        wb(1'b1, `ALM_ADR_CTRL, ctrl(4'h0, 1'b1, 1'b0, 1'b0, 4'h1, 3'h1));
        wb(1'b1, `ALM_ADR_IRQ, 32'hf);
        wb(1'b1, `ALM_ADR_MASK, 32'h1);
        lim <= 4'h1;
        settle(4);
        check("irq on rise", irq, 1'b1);
        wb(1'b1, `ALM_ADR_IRQ, 32'h1);
        repeat (2) @(posedge clk);
        check("irq cleared", irq, 1'b0);
        lim <= 4'h0;
        settle(4);
        wb(1'b1, `ALM_ADR_DELAY, {16'd6, 16'd4});
        lim <= 4'h1;
        settle(4);
        check("switch-in wait", alarm, 1'b0);
        settle(6);
        check("switch-in done", {alarm, irq}, 2'b11);
        wb(1'b1, `ALM_ADR_MASK, 32'h0);
        check("irq masked", irq, 1'b0);
        lim <= 4'h0;
        settle(5);
        check("dropout wait", alarm, 1'b1);
        settle(6);
        check("dropout done", alarm, 1'b0);
        wb(1'b1, `ALM_ADR_DELAY, 32'h0);
        wb(1'b1, `ALM_ADR_CTRL, ctrl(4'h0, 1'b0, 1'b0, 1'b0, 4'h1, 3'h1));
        lim <= 4'h1;
        settle(4);
        lim <= 4'h0;
        settle(4);
        wb(1'b0, `ALM_ADR_STATUS, 32'h0);
        check("no pending ack", {led, rdata[4]}, 2'b00);
        wb(1'b1, `ALM_ADR_IRQ, 32'hf);
        tick_en <= 1'b0;
        repeat (250) @(posedge clk);
        wb(1'b0, `ALM_ADR_IRQ, 32'h0);
        check("forced tick", rdata[2], 1'b1);
        tick_en  <= 1'b1;
        gain_chg <= 1'b1;
        lim      <= 4'h1;
        @(posedge clk);
        gain_chg <= 1'b0;
        settle(1);
        wb(1'b0, `ALM_ADR_STATUS, 32'h0);
        check("frozen", {rdata[5], rdata[0]}, 2'b10);
        settle(5);
        wb(1'b0, `ALM_ADR_STATUS, 32'h0);
        check("thawed", rdata[0], 1'b1);
        report_and_stop();
    end
endmodule : testbench
